/* logic/nsc_config_regs.sv */
// Purpose: Configuration register bank of a system switch node.
// Assumes: One access per cycle; reads answer in the next cycle.
// Notes:   PLL fields load boot values at the first edge after reset release.
// Operation
// RULE_01 - Registers reached only by configuration reads and writes by register number.
// RULE_02 - Identification top byte holds a read-only chip identifier.
// RULE_03 - Identification second byte shows boot pins captured at reset, fixed after.
// RULE_04 - Identification holds switch revision then version in low bytes, read-only.
// RULE_05 - Description reports links, attached cores and links per processor.
// RULE_06 - Top configuration bit set refuses every configuration write; resets zero.
// RULE_07 - Configuration bit 8 set blocks PLL register updates; resets zero.
// RULE_08 - Configuration bit 0 one selects single-byte headers; resets zero.
// RULE_09 - Configuring party programs the same header mode into every node.
// RULE_10 - Node identity is writable 16-bit low half, reset zero, upper reserved.
// RULE_11 - Routing compares node identity to destination from the most significant bit.
// RULE_12 - Any accepted PLL register write resets the processor tile.
// RULE_13 - PLL three-bit output divider writable, initial value from boot pins.
// RULE_14 - PLL thirteen-bit feedback multiplier writable, initial value from boot pins.
// RULE_15 - PLL seven-bit input divider writable, initial value from boot pins.
// RULE_16 - Refused writes change nothing; reserved bits read zero, ignore writes.
// RULE_17 - Boot pins pick the three PLL reset values from a fixed table.
`timescale 1ns/1ps
module nsc_config_regs
#(
    parameter logic [7:0] CHIP_ID       = 8'h5a, // Arbitrary value
    parameter logic [7:0] SWITCH_REV    = 8'h01, // Arbitrary value
    parameter logic [7:0] SWITCH_VER    = 8'h02, // Arbitrary value
    parameter logic [7:0] NUM_LINKS     = 8'h08,
    parameter logic [7:0] NUM_CORES     = 8'h01,
    parameter logic [7:0] LINKS_PER_CPU = 8'h04
)
(
    // Clock and reset
    input  wire logic                           i_core_clk,
    input  wire logic                           i_reset,
    input  wire logic                           i_clk_en,
    // Boot-select pins
    input  wire logic                           i_boot_select_pin_a,
    input  wire logic                           i_boot_select_pin_b,
    // Configuration access
    input  wire logic                           i_cfg_wr,
    input  wire logic                           i_cfg_rd,
    input  wire logic [7:0]                     i_cfg_addr,
    input  wire logic [31:0]                    i_cfg_wdata,
    output logic                                o_cfg_rvalid,
    output logic [31:0]                         o_cfg_rdata,
    output logic                                o_cfg_wr_refused,
    // Routing match
    input  wire logic [nsc_pkg::NODE_ID_W-1:0]  i_dest_id,
    output logic                                o_id_match,
    output logic [4:0]                          o_first_mismatch,
    // Switch state
    output logic                                o_single_byte_hdr,
    output logic [nsc_pkg::NODE_ID_W-1:0]       o_node_id,
    output logic [nsc_pkg::PLL_OD_W-1:0]        o_pll_output_divider,
    output logic [nsc_pkg::PLL_F_W-1:0]         o_pll_feedback_mult,
    output logic [nsc_pkg::PLL_R_W-1:0]         o_pll_input_divider,
    output logic                                o_tile_reset
);
    import nsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    nsc_boot_type         boot_state;
    nsc_boot_type         next_boot_state;
    logic [1:0]           boot_pins;
    logic [1:0]           next_boot_pins;
    logic                 all_lock;
    logic                 next_all_lock;
    logic                 pll_lock;
    logic                 next_pll_lock;
    logic                 hdr_mode;
    logic                 next_hdr_mode;
    logic [NODE_ID_W-1:0] node_id;
    logic [NODE_ID_W-1:0] next_node_id;
    logic [PLL_OD_W-1:0]  pll_od;
    logic [PLL_OD_W-1:0]  next_pll_od;
    logic [PLL_F_W-1:0]   pll_f;
    logic [PLL_F_W-1:0]   next_pll_f;
    logic [PLL_R_W-1:0]   pll_r;
    logic [PLL_R_W-1:0]   next_pll_r;
    logic                 tile_rst;
    logic                 next_tile_rst;
    logic                 rvalid;
    logic                 next_rvalid;
    logic [31:0]          rdata;
    logic [31:0]          next_rdata;
    logic                 refused;
    logic                 next_refused;
    logic [PLL_OD_W-1:0]  lut_od;
    logic [PLL_F_W-1:0]   lut_f;
    logic [PLL_R_W-1:0]   lut_r;
    logic [1:0]           lut_sel;
    logic                 wr_ok;
    logic                 pll_wr_ok;
    logic [31:0]          id_word;
    logic [31:0]          desc_word;
    logic [31:0]          cfg_word;
    logic [31:0]          nid_word;
    logic [31:0]          pll_word;

    ////////////////////////////////////////////////////////////////////////////
    // Boot lookup

    // Live pins feed the table while waiting, so the values are ready at release
    assign lut_sel = (boot_state == NSC_BOOT_WAIT) ? {i_boot_select_pin_b, i_boot_select_pin_a}
                                                   : boot_pins; // RULE_17

    nsc_boot_lut u_lut
    (
        .i_core_clk (i_core_clk),
        .i_clk_en   (i_clk_en),
        .i_boot_sel (lut_sel),
        .o_od       (lut_od),
        .o_f        (lut_f),
        .o_r        (lut_r)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read words, reserved bits zero

    always_comb
    begin
        id_word = ZERO_WORD;
        id_word[ID_CHIP_LSB +: 8] = CHIP_ID; // RULE_02
        id_word[ID_MODE_LSB +: 2] = boot_pins; // RULE_03
        id_word[ID_REV_LSB +: 8]  = SWITCH_REV; // RULE_04
        id_word[ID_VER_LSB +: 8]  = SWITCH_VER;
        desc_word = ZERO_WORD;
        desc_word[DESC_LINKS_LSB +: 8] = NUM_LINKS; // RULE_05
        desc_word[DESC_CORES_LSB +: 8] = NUM_CORES;
        desc_word[DESC_LPP_LSB +: 8]   = LINKS_PER_CPU;
        cfg_word = ZERO_WORD; // RULE_16
        cfg_word[CFG_ALL_LOCK_BIT] = all_lock;
        cfg_word[CFG_PLL_LOCK_BIT] = pll_lock;
        cfg_word[CFG_HDR_MODE_BIT] = hdr_mode;
        nid_word = ZERO_WORD;
        nid_word[NODE_ID_W-1:0] = node_id; // RULE_10
        pll_word = ZERO_WORD;
        pll_word[PLL_OD_LSB +: PLL_OD_W] = pll_od;
        pll_word[PLL_F_LSB +: PLL_F_W]   = pll_f;
        pll_word[PLL_R_LSB +: PLL_R_W]   = pll_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write gating and next values

    assign wr_ok     = i_cfg_wr && !all_lock; // RULE_06
    assign pll_wr_ok = wr_ok && !pll_lock && (i_cfg_addr == REG_PLL); // RULE_07

    always_comb
    begin
        next_boot_state = NSC_BOOT_DONE;
        next_boot_pins  = boot_pins;
        next_all_lock   = all_lock;
        next_pll_lock   = pll_lock;
        next_hdr_mode   = hdr_mode;
        next_node_id    = node_id;
        next_pll_od     = pll_od;
        next_pll_f      = pll_f;
        next_pll_r      = pll_r;
        next_tile_rst   = 1'b0;
        next_rvalid     = i_cfg_rd; // RULE_01
        next_rdata      = rdata;
        next_refused    = i_cfg_wr && !wr_ok;
        case (boot_state)
            NSC_BOOT_WAIT:
            begin
                // Pins captured once after reset release
                next_boot_pins = {i_boot_select_pin_b, i_boot_select_pin_a}; // RULE_03
            end
            NSC_BOOT_DONE:
            begin
                if (pll_wr_ok)
                begin
                    next_pll_od   = i_cfg_wdata[PLL_OD_LSB +: PLL_OD_W]; // RULE_13
                    next_pll_f    = i_cfg_wdata[PLL_F_LSB +: PLL_F_W]; // RULE_14
                    next_pll_r    = i_cfg_wdata[PLL_R_LSB +: PLL_R_W]; // RULE_15
                    next_tile_rst = 1'b1; // RULE_12
                end
                else if (wr_ok && i_cfg_addr == REG_PLL)
                begin
                    next_refused = 1'b1; // RULE_16
                end
                if (wr_ok && i_cfg_addr == REG_SWITCH_CFG)
                begin
                    next_all_lock = i_cfg_wdata[CFG_ALL_LOCK_BIT];
                    next_pll_lock = i_cfg_wdata[CFG_PLL_LOCK_BIT];
                    next_hdr_mode = i_cfg_wdata[CFG_HDR_MODE_BIT]; // RULE_08
                end
                if (wr_ok && i_cfg_addr == REG_NODE_ID)
                begin
                    next_node_id = i_cfg_wdata[NODE_ID_W-1:0]; // RULE_10
                end
            end
            default:
            begin
                next_boot_state = NSC_BOOT_WAIT;
            end
        endcase
        if (boot_state == NSC_BOOT_WAIT)
        begin
            next_pll_od = lut_od; // RULE_17
            next_pll_f  = lut_f;
            next_pll_r  = lut_r;
        end
        // Read mux with zero for unmapped numbers
        if (i_cfg_rd)
        begin
            case (i_cfg_addr)
                REG_NODE_IDENT:  next_rdata = id_word;
                REG_SWITCH_DESC: next_rdata = desc_word;
                REG_SWITCH_CFG:  next_rdata = cfg_word;
                REG_NODE_ID:     next_rdata = nid_word;
                REG_PLL:         next_rdata = pll_word;
                default:         next_rdata = ZERO_WORD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            boot_state <= NSC_BOOT_WAIT;
            boot_pins  <= 2'h0;
            all_lock   <= 1'b0;
            pll_lock   <= 1'b0;
            hdr_mode   <= 1'b0;
            node_id    <= 16'h0000;
            pll_od     <= 3'h0;
            pll_f      <= 13'h0000;
            pll_r      <= 7'h00;
            tile_rst   <= 1'b0;
            rvalid     <= 1'b0;
            rdata      <= 32'h0000_0000;
            refused    <= 1'b0;
        end
        else if (i_clk_en)
        begin
            boot_state <= next_boot_state;
            boot_pins  <= next_boot_pins;
            all_lock   <= next_all_lock;
            pll_lock   <= next_pll_lock;
            hdr_mode   <= next_hdr_mode;
            node_id    <= next_node_id;
            pll_od     <= next_pll_od;
            pll_f      <= next_pll_f;
            pll_r      <= next_pll_r;
            tile_rst   <= next_tile_rst;
            rvalid     <= next_rvalid;
            rdata      <= next_rdata;
            refused    <= next_refused;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Routing match, scanned from the top bit down

    always_comb
    begin
        o_first_mismatch = 5'h10;
        for (int b = 0; b < NODE_ID_W; b++)
        begin
            if (node_id[b] != i_dest_id[b])
            begin
                o_first_mismatch = 5'(b); // RULE_11
            end
        end
        o_id_match = (node_id == i_dest_id);
    end

    // Outputs
    assign o_cfg_rvalid         = rvalid;
    assign o_cfg_rdata          = rdata;
    assign o_cfg_wr_refused     = refused;
    assign o_single_byte_hdr    = hdr_mode;
    assign o_node_id            = node_id;
    assign o_pll_output_divider = pll_od;
    assign o_pll_feedback_mult  = pll_f;
    assign o_pll_input_divider  = pll_r;
    assign o_tile_reset         = tile_rst;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_all_lock_hold;
        @(posedge i_core_clk) disable iff (i_reset)
        (all_lock && i_clk_en) |=> (node_id == $past(node_id) && pll_f == $past(pll_f) && all_lock);
    endproperty
    a_all_lock_hold: assert property (p_all_lock_hold) else $error("write accepted under lock"); // RULE_06

    property p_pll_lock;
        @(posedge i_core_clk) disable iff (i_reset)
        (pll_lock && boot_state == NSC_BOOT_DONE && i_clk_en) |=> (pll_od == $past(pll_od) && !tile_rst);
    endproperty
    a_pll_lock: assert property (p_pll_lock) else $error("pll changed under lock"); // RULE_07

    property p_tile_reset;
        @(posedge i_core_clk) disable iff (i_reset)
        (pll_wr_ok && boot_state == NSC_BOOT_DONE && i_clk_en) |=> (tile_rst && pll_r == $past(i_cfg_wdata[6:0]));
    endproperty
    a_tile_reset: assert property (p_tile_reset) else $error("pll write missing tile reset"); // RULE_12

    property p_tile_cause;
        @(posedge i_core_clk) disable iff (i_reset)
        $rose(tile_rst) |-> $past(i_cfg_wr && i_cfg_addr == REG_PLL);
    endproperty
    a_tile_cause: assert property (p_tile_cause) else $error("tile reset without pll write"); // RULE_12

    property p_pins_fixed;
        @(posedge i_core_clk) disable iff (i_reset)
        (boot_state == NSC_BOOT_DONE) |=> (boot_pins == $past(boot_pins));
    endproperty
    a_pins_fixed: assert property (p_pins_fixed) else $error("boot pins changed"); // RULE_03

    property p_reserved_zero;
        @(posedge i_core_clk) disable iff (i_reset)
        (i_cfg_rd && i_clk_en && i_cfg_addr == REG_NODE_ID) |=> (o_cfg_rvalid && o_cfg_rdata[31:16] == 16'h0000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero"); // RULE_16

    property p_id_read;
        @(posedge i_core_clk) disable iff (i_reset)
        (i_cfg_rd && i_clk_en && i_cfg_addr == REG_NODE_IDENT) |=> (o_cfg_rdata[31:24] == CHIP_ID);
    endproperty
    a_id_read: assert property (p_id_read) else $error("chip id wrong"); // RULE_02

    property p_hdr_write;
        @(posedge i_core_clk) disable iff (i_reset)
        (wr_ok && i_clk_en && boot_state == NSC_BOOT_DONE && i_cfg_addr == REG_SWITCH_CFG)
        |=> (o_single_byte_hdr == $past(i_cfg_wdata[0]));
    endproperty
    a_hdr_write: assert property (p_hdr_write) else $error("header mode not written"); // RULE_08

    property p_match;
        @(posedge i_core_clk) disable iff (i_reset)
        o_id_match == (o_first_mismatch == 5'h10);
    endproperty
    a_match: assert property (p_match) else $error("match disagrees with scan"); // RULE_11

endmodule

/* logic/nsc_pkg.sv */
// Purpose: Shared constants for the node switch configuration register bank.
// Assumes: Registers are addressed by an 8-bit register number.
// Notes:   Boot lookup values are plain defaults, not taken from any real part.
package nsc_pkg;

    // Register numbers
    localparam logic [7:0] REG_NODE_IDENT   = 8'h00;
    localparam logic [7:0] REG_SWITCH_DESC  = 8'h01;
    localparam logic [7:0] REG_SWITCH_CFG   = 8'h04;
    localparam logic [7:0] REG_NODE_ID      = 8'h05;
    localparam logic [7:0] REG_PLL          = 8'h06;

    // Switch configuration field positions
    localparam int CFG_ALL_LOCK_BIT = 31;
    localparam int CFG_PLL_LOCK_BIT = 8;
    localparam int CFG_HDR_MODE_BIT = 0;

    // Node identity width
    localparam int NODE_ID_W = 16;

    // PLL field positions and widths
    localparam int PLL_OD_LSB = 23;
    localparam int PLL_OD_W   = 3;
    localparam int PLL_F_LSB  = 8;
    localparam int PLL_F_W    = 13;
    localparam int PLL_R_LSB  = 0;
    localparam int PLL_R_W    = 7;

    // Identification and description byte positions
    localparam int ID_CHIP_LSB = 24;
    localparam int ID_MODE_LSB = 16;
    localparam int ID_REV_LSB  = 8;
    localparam int ID_VER_LSB  = 0;
    localparam int DESC_LINKS_LSB = 16;
    localparam int DESC_CORES_LSB = 8;
    localparam int DESC_LPP_LSB   = 0;

    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // Boot-pin state of the capture step
    typedef enum logic [0:0]
    {
        NSC_BOOT_WAIT = 1'b0,
        NSC_BOOT_DONE = 1'b1
    } nsc_boot_type;

endpackage

/* logic/nsc_boot_lut.sv */
// Purpose: Fixed lookup of PLL reset values from the two boot-select pins.
// Assumes: Pin pair is stable; live pins feed it until they are captured.
// Notes:   Output fields are registered.
`timescale 1ns/1ps
module nsc_boot_lut
(
    // Clock and control
    input  wire logic                        i_core_clk,
    input  wire logic                        i_clk_en,
    // Boot pins
    input  wire logic [1:0]                  i_boot_sel,
    // Reset values
    output logic [nsc_pkg::PLL_OD_W-1:0]     o_od,
    output logic [nsc_pkg::PLL_F_W-1:0]      o_f,
    output logic [nsc_pkg::PLL_R_W-1:0]      o_r
);
    import nsc_pkg::*;

    logic [PLL_OD_W-1:0] next_od;
    logic [PLL_F_W-1:0]  next_f;
    logic [PLL_R_W-1:0]  next_r;

    // Table of reset values per pin pair
    always_comb
    begin
        case (i_boot_sel)
            2'h0:
            begin
                next_od = 3'h1;
                next_f  = 13'h0013;
                next_r  = 7'h00;
            end
            2'h1:
            begin
                next_od = 3'h1;
                next_f  = 13'h0027;
                next_r  = 7'h01;
            end
            2'h2:
            begin
                next_od = 3'h2;
                next_f  = 13'h003f;
                next_r  = 7'h01;
            end
            default:
            begin
                next_od = 3'h0;
                next_f  = 13'h0007;
                next_r  = 7'h00;
            end
        endcase
    end

    // Register the looked-up values
    always_ff @(posedge i_core_clk)
    begin
        if (i_clk_en)
        begin
            o_od <= next_od; // RULE_17
            o_f  <= next_f;
            o_r  <= next_r;
        end
    end

endmodule

/* verification/nsc_cfg_requester.sv */
// Purpose: Model of the party issuing configuration reads and writes.
// Assumes: One-cycle strobes, changed just after the rising edge.
// Notes:   Idle lines show a changing pattern so stale values never pass.
`timescale 1ns/1ps
module nsc_cfg_requester
(
    // Clock
    input  wire logic   i_core_clk,
    // Request lines
    output logic        o_wr,
    output logic        o_rd,
    output logic [7:0]  o_addr,
    output logic [31:0] o_wdata
);
    ////////////////////////////////////////////////////////////////
    // Quiet bus at time zero
    initial
    begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_wdata = 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////
    // One request per cycle, addressed by register number
    task automatic put(input logic wr, input logic rd, input logic [7:0] addr, input logic [31:0] data);
        @(posedge i_core_clk);
        #1;
        o_wr = wr;
        o_rd = rd;
        o_addr = addr;
        o_wdata = data;
    endtask

    // Release: strobes low, address and data inverted
    task automatic drop();
        @(posedge i_core_clk);
        #1;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = ~o_addr;
        o_wdata = ~o_wdata;
    endtask
endmodule

/* verification/node_switch_config_regs_test.sv */
// Purpose: Self-checking bench of the node switch configuration registers.
// Assumes: Boot pins held steady through reset and after it.
// Notes:   Reads and write outcomes are queued and checked by a watcher.
`timescale 1ns/1ps
module node_switch_config_regs_test;
    import nsc_pkg::*;
    localparam logic [7:0] CHIP = 8'h5a; // Arbitrary value
    localparam logic [7:0] REV  = 8'h01; // Arbitrary value
    localparam logic [7:0] VER  = 8'h02; // Arbitrary value
    localparam logic [31:0] PLL_MASK = 32'h039f_ff7f;
    logic        clk, rst, pin_a, pin_b, wr, rd, rvalid, refused, match, hdr, tile_rst, wr_last, e_hdr, ce;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, d, nid_w, pll_w;
    logic [15:0] dest, nid;
    logic [4:0]  fmis;
    logic [2:0]  od;
    logic [12:0] f;
    logic [6:0]  r;
    logic [1:0]  boot;
    int          error_cnt, cmp_count, seed;
    logic [31:0] rd_q[$];
    logic [1:0]  wr_q[$];

    ////////////////////////////////////////////////////////////////
    // Design, far-side requester and clock
    nsc_config_regs #(.CHIP_ID(CHIP), .SWITCH_REV(REV), .SWITCH_VER(VER), .NUM_LINKS(8'h08),
        .NUM_CORES(8'h01), .LINKS_PER_CPU(8'h04)) u_dut
    (
        .i_core_clk(clk), .i_reset(rst), .i_clk_en(ce),
        .i_boot_select_pin_a(pin_a), .i_boot_select_pin_b(pin_b),
        .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr), .i_cfg_wdata(wdata),
        .o_cfg_rvalid(rvalid), .o_cfg_rdata(rdata), .o_cfg_wr_refused(refused),
        .i_dest_id(dest), .o_id_match(match), .o_first_mismatch(fmis),
        .o_single_byte_hdr(hdr), .o_node_id(nid), .o_pll_output_divider(od),
        .o_pll_feedback_mult(f), .o_pll_input_divider(r), .o_tile_reset(tile_rst)
    );
    nsc_cfg_requester u_req (.i_core_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////
    // Expected PLL fields for boot pairs {b,a} 00 and 11 only
    function automatic logic [22:0] lut(input logic [1:0] k);
        return (k == 2'b11) ? {3'h0, 13'h0007, 7'h00} : {3'h1, 13'h0013, 7'h00};
    endfunction
    function automatic logic [31:0] pll_word(input logic [22:0] x);
        return {6'h00, x[22:20], 2'h0, x[19:7], 1'h0, x[6:0]};
    endfunction

    // Comparisons
    task automatic compare_word(input logic [31:0] exp, input logic [31:0] act);
        cmp_count++;
        if (act !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, act);
        end
    endtask
    task automatic compare_flags(input logic [1:0] exp, input logic [1:0] act);
        cmp_count++;
        if (act !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, act);
        end
    endtask
    task automatic summarize();
        // Notes never answered add one mismatch in all
        if (rd_q.size() != 0 || wr_q.size() != 0)
            error_cnt++;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Requests with their expected outcomes; flags are {refused, tile reset}
    task automatic w(input logic [7:0] a, input logic [31:0] v, input logic [1:0] fl);
        u_req.put(1'b1, 1'b0, a, v);
        wr_q.push_back(fl);
    endtask
    task automatic rq(input logic [7:0] a, input logic [31:0] e);
        u_req.put(1'b0, 1'b1, a, $random(seed));
        rd_q.push_back(e);
    endtask
    task automatic settle();
        u_req.drop();
        repeat (2) @(posedge clk);
        @(negedge clk);
        compare_word({31'h0, e_hdr}, {31'h0, hdr});
        compare_word(nid_w, {16'h0, nid});
        compare_word({9'h0, pll_w[25:23], pll_w[20:8], pll_w[6:0]}, {9'h0, od, f, r});
    endtask
    task automatic check_reset();
        rq(REG_NODE_IDENT, {CHIP, 6'h00, boot, REV, VER});
        rq(REG_SWITCH_DESC, 32'h0008_0104);
        rq(REG_SWITCH_CFG, 32'h0);
        rq(REG_NODE_ID, 32'h0);
        rq(REG_PLL, pll_w);
        rq(8'h02, 32'h0);
        settle();
    endtask
    // Destination match scanned from the top bit down
    task automatic route();
        logic [4:0] efm;
        for (int n = 0; n < 6; n++)
        begin
            @(posedge clk);
            #1;
            dest = (n == 0) ? nid_w[15:0] : 16'($random(seed));
            @(negedge clk);
            efm = 5'd16;
            for (int i = 0; i < 16; i++)
                if (dest[i] != nid_w[i])
                    efm = 5'(i);
            compare_word({27'h0, efm}, {27'h0, fmis});
            compare_word({31'h0, dest == nid_w[15:0]}, {31'h0, match});
        end
    endtask
    task automatic do_reset(input logic a, input logic b);
        @(posedge clk);
        #1;
        rst = 1'b1;
        pin_a = a;
        pin_b = b;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge clk);
        boot = {b, a};
        e_hdr = 1'b0;
        nid_w = 32'h0;
        pll_w = pll_word(lut(boot));
    endtask

    ////////////////////////////////////////////////////////////////
    // Watcher: takes the oldest note whenever a result appears
    always @(posedge clk)
        wr_last <= wr;
    always @(negedge clk)
    begin
        if (rvalid === 1'b1)
        begin
            if (rd_q.size() == 0)
                compare_word(32'h0, 32'hffff_ffff);
            else
                compare_word(rd_q.pop_front(), rdata);
        end
        if (wr_last === 1'b1 && wr_q.size() > 0)
            compare_flags(wr_q.pop_front(), {refused, tile_rst});
    end

    // Watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        seed = 32'hf7fb;
        error_cnt = 0;
        cmp_count = 0;
        rst = 1'b1;
        pin_a = 1'b0;
        pin_b = 1'b0;
        dest = 16'h0000;
        ce = 1'b1;
        repeat (3) @(posedge clk);
        do_reset(1'b0, 1'b0);
        check_reset();
        route();
        $display("test reset values done");
        for (int n = 0; n < 4; n++)
        begin
            d = $random(seed);
            w(REG_NODE_ID, d, 2'b00);
            nid_w = {16'h0, d[15:0]};
            rq(REG_NODE_ID, nid_w);
        end
        w(REG_NODE_IDENT, 32'hffff_ffff, 2'b00);
        w(REG_SWITCH_DESC, 32'hffff_ffff, 2'b00);
        rq(REG_NODE_IDENT, {CHIP, 8'h00, REV, VER});
        rq(REG_SWITCH_DESC, 32'h0008_0104);
        settle();
        route();
        $display("test node identity done");
        for (int n = 0; n < 3; n++)
        begin
            d = $random(seed);
            w(REG_PLL, d, 2'b01);
            pll_w = d & PLL_MASK;
        end
        rq(REG_PLL, pll_w);
        settle();
        $display("test pll writes done");
        // Same header mode on every node, this model stands for all of them
        w(REG_SWITCH_CFG, 32'h7fff_fe01, 2'b00);
        e_hdr = 1'b1;
        rq(REG_SWITCH_CFG, 32'h0000_0001);
        settle();
        $display("test header mode done");
        w(REG_SWITCH_CFG, 32'h0000_0101, 2'b00);
        w(REG_PLL, $random(seed), 2'b10);
        d = $random(seed);
        w(REG_NODE_ID, d, 2'b00);
        nid_w = {16'h0, d[15:0]};
        rq(REG_PLL, pll_w);
        rq(REG_SWITCH_CFG, 32'h0000_0101);
        settle();
        $display("test pll lock done");
        // A write while the clock enable is low must leave every register alone
        @(posedge clk);
        #1;
        ce = 1'b0;
        u_req.put(1'b1, 1'b0, REG_NODE_ID, $random(seed));
        u_req.drop();
        ce = 1'b1;
        settle();
        $display("test clock enable done");
        w(REG_SWITCH_CFG, 32'h8000_0101, 2'b00);
        w(REG_NODE_ID, $random(seed), 2'b10);
        w(REG_SWITCH_CFG, 32'h0000_0000, 2'b10);
        w(REG_PLL, $random(seed), 2'b10);
        rq(REG_NODE_ID, nid_w);
        rq(REG_SWITCH_CFG, 32'h8000_0101);
        settle();
        $display("test write lock done");
        do_reset(1'b1, 1'b1);
        check_reset();
        route();
        $display("test second reset done");
        summarize();
    end
endmodule
